// ---- hdl/camd_datapath.sv ----
// Purpose: arithmetic, logic and multiply datapath of the 8-bit core
// Assumes: decoder holds operands while i_start is high and o_busy low
// Notes: status flags live here and are presented on o_flags
//
// Summary of operation
// [RL1] add word immediate to pair, flags Z C N V S, two cycles
// [RL2] subtract word immediate from pair, flags Z C N V S, two cycles
// [RL3] byte minus constant minus carry, all six flags, one cycle
// [RL4] and with constant, flags Z N V S only, one cycle
// [RL5] or with constant, flags Z N V S only, one cycle
// [RL6] test ands register with itself, sets Z N V S, one cycle
// [RL7] signed by unsigned product into product pair, Z C, two cycles
// [RL8] fractional product shifted left once, Z C, two cycles
// [RL9] invert is FF minus, negate is 00 minus, one cycle each
// [RL10] Z on zero result, N msb, S is N xor V, C H from carries
// [RL11] flags an operation does not list keep their old value
`timescale 1ns/1ps
`default_nettype none
module camd_datapath (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire camd_pkg::camd_op_t i_op,
	input wire logic [7:0] i_rd,
	input wire logic [7:0] i_rd_hi,
	input wire logic [7:0] i_imm,
	input wire logic [7:0] i_rr,
	output logic o_busy,
	output logic o_done,
	output logic o_wr_reg,
	output logic o_wr_pair,
	output logic o_wr_prod,
	output logic [15:0] o_result,
	output logic [5:0] o_flags
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		camd_pkg::camd_st_t st;
		logic [1:0] cnt;
		camd_pkg::camd_op_t op;
		logic [15:0] pend;
		logic [5:0] pflg;
		logic [15:0] res;
		logic [5:0] flg;
		logic done;
		logic wr_reg;
		logic wr_pair;
		logic wr_prod;
	} camd_state_t;

	camd_state_t s_ff;
	camd_state_t nxt_s;
	logic accept;
	logic is_mul;
	logic is_word;
	logic [15:0] mul_prod;
	logic mul_carry;

	assign accept = i_start && (s_ff.st == camd_pkg::CAMD_IDLE);
	assign is_mul = (i_op == camd_pkg::CAMD_MUL_SIGNED_UNSIGNED) ||
		(i_op == camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED);
	assign is_word = (i_op == camd_pkg::CAMD_ADD_IMM_WORD) ||
		(i_op == camd_pkg::CAMD_SUB_IMM_WORD);

	// ----------------------------------------------------------------
	// multiplier
	// ----------------------------------------------------------------
	camd_mul u_mul (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_load(accept && is_mul),
		.i_frac(i_op == camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED),
		.i_sgn_opnd(i_rd),
		.i_uns_opnd(i_rr),
		.o_product(mul_prod),
		.o_carry(mul_carry)
	);

	// ----------------------------------------------------------------
	// result and flag evaluation
	// ----------------------------------------------------------------
	always_comb begin
		logic [5:0] nf;
		logic [15:0] pair;
		logic [15:0] r16;
		logic [7:0] r8;
		logic [8:0] d9;
		logic [4:0] h5;
		logic cin;
		nf = s_ff.flg; // see [RL11]
		pair = {i_rd_hi, i_rd};
		r16 = '0;
		r8 = '0;
		d9 = '0;
		h5 = '0;
		cin = s_ff.flg[camd_pkg::CAMD_FLG_C];
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.wr_reg = 1'b0;
		nxt_s.wr_pair = 1'b0;
		nxt_s.wr_prod = 1'b0;
		unique case (i_op)
			camd_pkg::CAMD_ADD_IMM_WORD: begin
				r16 = pair + {10'h000, i_imm[5:0]}; // see [RL1]
				nf[camd_pkg::CAMD_FLG_V] = ~pair[15] & r16[15];
				nf[camd_pkg::CAMD_FLG_C] = pair[15] & ~r16[15];
			end
			camd_pkg::CAMD_SUB_IMM_WORD: begin
				r16 = pair - {10'h000, i_imm[5:0]}; // see [RL2]
				nf[camd_pkg::CAMD_FLG_V] = pair[15] & ~r16[15];
				nf[camd_pkg::CAMD_FLG_C] = r16[15] & ~pair[15];
			end
			camd_pkg::CAMD_SUB_IMM_WITH_CARRY: begin
				d9 = {1'b0, i_rd} - {1'b0, i_imm} - {8'h00, cin}; // see [RL3]
				h5 = {1'b0, i_rd[3:0]} - {1'b0, i_imm[3:0]} - {4'h0, cin};
				r8 = d9[7:0];
				nf[camd_pkg::CAMD_FLG_C] = d9[8]; // see [RL10]
				nf[camd_pkg::CAMD_FLG_H] = h5[4];
				nf[camd_pkg::CAMD_FLG_V] = (i_rd[7] ^ i_imm[7]) &
					(i_rd[7] ^ d9[7]);
			end
			camd_pkg::CAMD_AND_IMM: begin
				r8 = i_rd & i_imm; // see [RL4]
				nf[camd_pkg::CAMD_FLG_V] = 1'b0;
			end
			camd_pkg::CAMD_OR_IMM: begin
				r8 = i_rd | i_imm; // see [RL5]
				nf[camd_pkg::CAMD_FLG_V] = 1'b0;
			end
			camd_pkg::CAMD_TEST_ZERO_MINUS: begin
				r8 = i_rd & i_rd; // see [RL6]
				nf[camd_pkg::CAMD_FLG_V] = 1'b0;
			end
			camd_pkg::CAMD_BITWISE_INVERT: begin
				r8 = camd_pkg::CAMD_ALL_ONES - i_rd; // see [RL9]
				nf[camd_pkg::CAMD_FLG_C] = 1'b1;
				nf[camd_pkg::CAMD_FLG_V] = 1'b0;
			end
			camd_pkg::CAMD_ARITH_INVERSE: begin
				r8 = camd_pkg::CAMD_ALL_ZERO - i_rd; // see [RL9]
				nf[camd_pkg::CAMD_FLG_C] = (r8 != 8'h00);
				nf[camd_pkg::CAMD_FLG_H] = r8[3] | i_rd[3];
				nf[camd_pkg::CAMD_FLG_V] = (r8 == camd_pkg::CAMD_MOST_NEG);
			end
			camd_pkg::CAMD_MUL_SIGNED_UNSIGNED,
			camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED: begin
				// product flags are taken when the multiplier answers
				r8 = '0;
			end
		endcase
		if (!is_mul) begin
			if (!is_word) begin
				r16 = {8'h00, r8};
				nf[camd_pkg::CAMD_FLG_N] = r8[7]; // see [RL10]
				nf[camd_pkg::CAMD_FLG_Z] = (r8 == 8'h00);
			end else begin
				nf[camd_pkg::CAMD_FLG_N] = r16[15];
				nf[camd_pkg::CAMD_FLG_Z] = (r16 == 16'h0000);
			end
			nf[camd_pkg::CAMD_FLG_S] = nf[camd_pkg::CAMD_FLG_N] ^
				nf[camd_pkg::CAMD_FLG_V]; // see [RL10]
		end

		// ------------------------------------------------------------
		// sequencer: byte ops finish at once, word and mul take two
		// ------------------------------------------------------------
		unique case (s_ff.st)
			camd_pkg::CAMD_IDLE: begin
				if (accept) begin
					if (!is_mul && !is_word) begin
						// one-cycle family
						nxt_s.res = r16;
						nxt_s.flg = nf;
						nxt_s.done = (camd_pkg::CAMD_CYC_BYTE == 1);
						nxt_s.wr_reg = 1'b1;
					end else begin
						nxt_s.st = camd_pkg::CAMD_RUN;
						nxt_s.cnt = is_mul ? 2'(camd_pkg::CAMD_CYC_MUL - 2) :
							2'(camd_pkg::CAMD_CYC_WORD - 2); // see [RL1] [RL2]
						nxt_s.op = i_op;
						nxt_s.pend = r16;
						nxt_s.pflg = nf;
					end
				end
			end
			camd_pkg::CAMD_RUN: begin
				if (s_ff.cnt == 2'h0) begin
					nxt_s.st = camd_pkg::CAMD_IDLE;
					nxt_s.done = 1'b1;
					if ((s_ff.op == camd_pkg::CAMD_MUL_SIGNED_UNSIGNED) ||
						(s_ff.op == camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED)) begin
						nxt_s.res = mul_prod; // see [RL7] [RL8]
						nxt_s.flg[camd_pkg::CAMD_FLG_C] = mul_carry;
						nxt_s.flg[camd_pkg::CAMD_FLG_Z] = (mul_prod == 16'h0000);
						nxt_s.wr_prod = 1'b1;
					end else begin
						nxt_s.res = s_ff.pend;
						nxt_s.flg = s_ff.pflg; // see [RL11]
						nxt_s.wr_pair = 1'b1;
					end
				end else begin
					nxt_s.cnt = s_ff.cnt - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '{st: camd_pkg::CAMD_IDLE, op: camd_pkg::CAMD_ADD_IMM_WORD,
				flg: camd_pkg::CAMD_FLG_RST, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_busy = (s_ff.st == camd_pkg::CAMD_RUN);
	assign o_done = s_ff.done;
	assign o_wr_reg = s_ff.wr_reg;
	assign o_wr_pair = s_ff.wr_pair;
	assign o_wr_prod = s_ff.wr_prod;
	assign o_result = s_ff.res;
	assign o_flags = s_ff.flg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	logic [15:0] exp_mul;
	assign exp_mul = 16'(({{8{i_rd[7]}}, i_rd}) * {8'h00, i_rr});

	AST_WORD_TWO_CYCLES: assert property ( // see [RL1]
		accept && is_word |=> !o_done ##1 (o_done && o_wr_pair))
		else $error("word op did not finish in two cycles");

	AST_WORD_KEEPS_H: assert property ( // see [RL2]
		accept && is_word |-> ##2
		(o_flags[camd_pkg::CAMD_FLG_H] == $past(o_flags[camd_pkg::CAMD_FLG_H], 2)))
		else $error("word op changed half carry");

	AST_SUB_IMM_WITH_CARRY_VALUE: assert property ( // see [RL3]
		accept && i_op == camd_pkg::CAMD_SUB_IMM_WITH_CARRY |=>
		o_done && o_wr_reg && (o_result[7:0] == 8'($past(i_rd) - $past(i_imm) -
		{7'h00, $past(o_flags[camd_pkg::CAMD_FLG_C])})))
		else $error("subtract with carry result wrong");

	AST_LOGIC_KEEPS_CH: assert property ( // see [RL4]
		accept && (i_op == camd_pkg::CAMD_AND_IMM ||
		i_op == camd_pkg::CAMD_OR_IMM) |=>
		$stable(o_flags[camd_pkg::CAMD_FLG_C]) &&
		$stable(o_flags[camd_pkg::CAMD_FLG_H]) &&
		!o_flags[camd_pkg::CAMD_FLG_V])
		else $error("logic op touched carry, half carry or overflow");

	AST_TEST_KEEPS_VALUE: assert property ( // see [RL6]
		accept && i_op == camd_pkg::CAMD_TEST_ZERO_MINUS |=>
		o_result[7:0] == $past(i_rd) &&
		o_flags[camd_pkg::CAMD_FLG_N] == $past(i_rd[7]))
		else $error("test altered value or negative flag");

	AST_MUL_VALUE: assert property ( // see [RL7]
		accept && i_op == camd_pkg::CAMD_MUL_SIGNED_UNSIGNED |-> ##2
		(o_wr_prod && o_result == $past(exp_mul, 2) &&
		o_flags[camd_pkg::CAMD_FLG_C] == o_result[15]))
		else $error("signed by unsigned product wrong");

	AST_INVERT_CARRY: assert property ( // see [RL9]
		accept && i_op == camd_pkg::CAMD_BITWISE_INVERT |=>
		o_flags[camd_pkg::CAMD_FLG_C] && o_result[7:0] == ~$past(i_rd))
		else $error("invert result or carry wrong");

	AST_SIGN_RELATION: assert property ( // see [RL10]
		o_flags[camd_pkg::CAMD_FLG_S] ==
		(o_flags[camd_pkg::CAMD_FLG_N] ^ o_flags[camd_pkg::CAMD_FLG_V]))
		else $error("sign flag differs from negative xor overflow");

	AST_ZERO_FLAG: assert property ( // see [RL10]
		(o_wr_reg |-> o_flags[camd_pkg::CAMD_FLG_Z] == (o_result[7:0] == 8'h00))
		and (o_wr_pair |-> o_flags[camd_pkg::CAMD_FLG_Z] == (o_result == 16'h0000)))
		else $error("zero flag does not match result");

	AST_IDLE_FLAGS_HOLD: assert property ( // see [RL11]
		!$past(accept) && !o_done |-> $stable(o_flags))
		else $error("flags changed without a finishing operation");

	COV_WORD_ADD: cover property (accept && i_op == camd_pkg::CAMD_ADD_IMM_WORD);
	COV_FRAC_MUL: cover property (
		accept && i_op == camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED ##2 o_wr_prod);
	COV_NEG_OVF: cover property (o_wr_reg && o_flags[camd_pkg::CAMD_FLG_V]);
	COV_BACK_TO_BACK: cover property (o_done && accept);

endmodule
`default_nettype wire

// ---- hdl/camd_mul.sv ----
// Purpose: signed-by-unsigned 8x8 multiplier with one register stage
// Assumes: operands are stable in the cycle that i_load is high
// Notes: product and carry appear one edge after the load
`timescale 1ns/1ps
`default_nettype none
module camd_mul (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic i_frac,
	input wire logic [7:0] i_sgn_opnd,
	input wire logic [7:0] i_uns_opnd,
	output logic [15:0] o_product,
	output logic o_carry
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] prod;
		logic carry;
	} camd_mul_state_t;

	camd_mul_state_t s_ff;
	camd_mul_state_t nxt_s;
	logic [15:0] raw;

	// ----------------------------------------------------------------
	// multiply
	// ----------------------------------------------------------------
	// low 16 bits of the sign-extended by zero-extended product are exact
	always_comb begin
		raw = 16'(({{8{i_sgn_opnd[7]}}, i_sgn_opnd}) * {8'h00, i_uns_opnd});
		nxt_s = s_ff;
		if (i_load) begin
			// carry is bit 15 before any fractional shift
			nxt_s.carry = raw[15]; // see [RL7]
			nxt_s.prod = i_frac ? {raw[14:0], 1'b0} : raw; // see [RL8]
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_product = s_ff.prod;
	assign o_carry = s_ff.carry;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_MUL_FRAC_LSB: assert property ( // see [RL8]
		@(posedge i_core_clk) disable iff (i_rst)
		i_load && i_frac |=> !o_product[0])
		else $error("fractional product lsb not zero");

endmodule
`default_nettype wire

// ---- hdl/camd_pkg.sv ----
// Purpose: shared constants and types of the alu and multiply datapath
// Assumes: 8-bit operands, 16-bit register pairs, one core clock
// Notes: flag positions follow the status byte layout used by the core
package camd_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CAMD_DATA_W = 8;
	localparam int CAMD_WORD_W = 16;
	localparam int CAMD_WIMM_W = 6;
	localparam int CAMD_FLG_W = 6;

	// ----------------------------------------------------------------
	// flag positions inside the status vector
	// ----------------------------------------------------------------
	localparam int CAMD_FLG_C = 0;
	localparam int CAMD_FLG_Z = 1;
	localparam int CAMD_FLG_N = 2;
	localparam int CAMD_FLG_V = 3;
	localparam int CAMD_FLG_S = 4;
	localparam int CAMD_FLG_H = 5;
	localparam logic [5:0] CAMD_FLG_RST = 6'h00;

	// ----------------------------------------------------------------
	// operand constants and cycle counts
	// ----------------------------------------------------------------
	localparam logic [7:0] CAMD_ALL_ONES = 8'hFF;
	localparam logic [7:0] CAMD_ALL_ZERO = 8'h00;
	localparam logic [7:0] CAMD_MOST_NEG = 8'h80;
	localparam int CAMD_CYC_WORD = 2;
	localparam int CAMD_CYC_MUL = 2;
	localparam int CAMD_CYC_BYTE = 1;

	// ----------------------------------------------------------------
	// operations and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CAMD_ADD_IMM_WORD,
		CAMD_SUB_IMM_WORD,
		CAMD_SUB_IMM_WITH_CARRY,
		CAMD_AND_IMM,
		CAMD_OR_IMM,
		CAMD_TEST_ZERO_MINUS,
		CAMD_MUL_SIGNED_UNSIGNED,
		CAMD_FRAC_MUL_SIGNED_UNSIGNED,
		CAMD_BITWISE_INVERT,
		CAMD_ARITH_INVERSE
	} camd_op_t;

	typedef enum logic [0:0] {
		CAMD_IDLE,
		CAMD_RUN
	} camd_st_t;

endpackage

// ---- sim/camd_rf_model.sv ----
// Purpose: register file model on the far side of the datapath
// Assumes: write strobes are one-cycle pulses that come with o_done
// Notes: keeps only the byte, pair and product write-back targets
`timescale 1ns/1ps
`default_nettype none
module camd_rf_model (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_wr_reg,
	input wire logic i_wr_pair,
	input wire logic i_wr_prod,
	input wire logic [15:0] i_result,
	output logic [7:0] o_reg,
	output logic [15:0] o_pair,
	output logic [15:0] o_prod
);
	// a stuck strobe shows up as a target overwritten by a later result
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg <= 8'h00;
			o_pair <= 16'h0000;
			o_prod <= 16'h0000;
		end else begin
			if (i_wr_reg) o_reg <= i_result[7:0];
			if (i_wr_pair) o_pair <= i_result;
			if (i_wr_prod) o_prod <= i_result;
		end
	end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the alu and multiply datapath
// Assumes: inputs change on the falling edge, outputs read there too
// Notes: expected results and flags come from a local reference
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_core_clk, i_rst, i_start, o_busy, o_done;
	logic o_wr_reg, o_wr_pair, o_wr_prod;
	camd_pkg::camd_op_t i_op;
	logic [7:0] i_rd, i_rd_hi, i_imm, i_rr, m_reg;
	logic [15:0] o_result, m_pair, m_prod;
	logic [5:0] o_flags, ef;
	int fails, check_count;
	camd_datapath dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_start(i_start), .i_op(i_op), .i_rd(i_rd), .i_rd_hi(i_rd_hi),
		.i_imm(i_imm), .i_rr(i_rr), .o_busy(o_busy), .o_done(o_done),
		.o_wr_reg(o_wr_reg), .o_wr_pair(o_wr_pair), .o_wr_prod(o_wr_prod),
		.o_result(o_result), .o_flags(o_flags));
	camd_rf_model rf_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_wr_reg(o_wr_reg), .i_wr_pair(o_wr_pair), .i_wr_prod(o_wr_prod),
		.i_result(o_result), .o_reg(m_reg), .o_pair(m_pair), .o_prod(m_prod));
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// reference: returns {result, flags}
	// ----------------------------------------------------------------
	function automatic logic [21:0] ref_op(input camd_pkg::camd_op_t op,
		input logic [7:0] d, h, k, q, input logic [5:0] f);
		logic [16:0] w;
		logic [15:0] r;
		logic [8:0] b;
		logic [5:0] g;
		g = f;
		w = {1'b0, h, d};
		r = 16'h0000;
		case (op)
		camd_pkg::CAMD_ADD_IMM_WORD: begin
			w = w + {11'h000, k[5:0]};
			g[3] = ~h[7] & w[15];
		end
		camd_pkg::CAMD_SUB_IMM_WORD: begin
			w = w - {11'h000, k[5:0]};
			g[3] = h[7] & ~w[15];
		end
		camd_pkg::CAMD_SUB_IMM_WITH_CARRY: begin
			b = {1'b0, d} - {1'b0, k} - {8'h00, f[0]};
			r = {8'h00, b[7:0]};
			g[0] = b[8];
			g[5] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
			g[3] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
		end
		camd_pkg::CAMD_AND_IMM: r = {8'h00, d & k};
		camd_pkg::CAMD_OR_IMM: r = {8'h00, d | k};
		camd_pkg::CAMD_TEST_ZERO_MINUS: r = {8'h00, d};
		camd_pkg::CAMD_BITWISE_INVERT: begin
			r = {8'h00, 8'hFF - d};
			g[0] = 1'b1;
		end
		camd_pkg::CAMD_ARITH_INVERSE: begin
			r = {8'h00, 8'h00 - d};
			g[0] = (r != 16'h0000);
			g[3] = (r == 16'h0080);
			g[5] = r[3] | d[3];
		end
		default: begin
			r = {{8{d[7]}}, d} * {8'h00, q};
			g[0] = r[15];
			if (op == camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED) r = r << 1;
			g[1] = (r == 16'h0000);
			return {r, g};
		end
		endcase
		if (op inside {camd_pkg::CAMD_SUB_IMM_WITH_CARRY,
			camd_pkg::CAMD_ARITH_INVERSE}) begin
		end else if (op <= camd_pkg::CAMD_SUB_IMM_WORD) begin
			r = w[15:0];
			g[0] = w[16];
		end else begin
			g[3] = 1'b0;
		end
		g[1] = (r == 16'h0000);
		g[2] = (op <= camd_pkg::CAMD_SUB_IMM_WORD) ? r[15] : r[7];
		g[4] = g[2] ^ g[3];
		return {r, g};
	endfunction
	task automatic drv(input camd_pkg::camd_op_t op, input logic [7:0] d, h, k,
		q);
		i_op = op;
		i_rd = d;
		i_rd_hi = h;
		i_imm = k;
		i_rr = q;
		i_start = 1'b1;
	endtask
	// ----------------------------------------------------------------
	// one request, latency, result, flags and write-back
	// ----------------------------------------------------------------
	task automatic run_op(input camd_pkg::camd_op_t op, input logic [7:0] d, h,
		k, q);
		logic [21:0] e;
		int n;
		e = ref_op(op, d, h, k, q, ef);
		ef = e[5:0];
		drv(op, d, h, k, q);
		@(negedge i_core_clk);
		i_start = 1'b0;
		{i_rd, i_rd_hi, i_imm, i_rr} = ~{d, h, k, q};
		n = 1;
		while (o_done !== 1'b1 && n < 6) begin
			@(negedge i_core_clk);
			n++;
		end
		chk(16'(n), (op <= camd_pkg::CAMD_SUB_IMM_WORD || op >=
			camd_pkg::CAMD_MUL_SIGNED_UNSIGNED &&
			op <= camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED) ? 16'h2 : 16'h1);
		chk(o_result, e[21:6]);
		chk(16'(o_flags), 16'(ef));
		@(negedge i_core_clk);
		chk(16'(o_done), 16'h0);
		if (op <= camd_pkg::CAMD_SUB_IMM_WORD) chk(m_pair, e[21:6]);
		else if (op == camd_pkg::CAMD_MUL_SIGNED_UNSIGNED ||
			op == camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED) chk(m_prod, e[21:6]);
		else if (op != camd_pkg::CAMD_TEST_ZERO_MINUS) chk(16'(m_reg), e[21:6]);
	endtask
	task automatic sc_ops();
		run_op(camd_pkg::CAMD_ADD_IMM_WORD, 8'hC1, 8'hFF, 8'h3F, 8'h00);
		run_op(camd_pkg::CAMD_SUB_IMM_WITH_CARRY, 8'h10, 8'h00, 8'h0F, 8'h00);
		run_op(camd_pkg::CAMD_ADD_IMM_WORD, 8'hFF, 8'h7F, 8'hC1, 8'h00);
		run_op(camd_pkg::CAMD_SUB_IMM_WORD, 8'h00, 8'h80, 8'h01, 8'h00);
		run_op(camd_pkg::CAMD_AND_IMM, 8'h80, 8'h00, 8'hFF, 8'h00);
		run_op(camd_pkg::CAMD_OR_IMM, 8'h00, 8'h00, 8'h00, 8'h00);
		run_op(camd_pkg::CAMD_TEST_ZERO_MINUS, 8'h9C, 8'h00, 8'h00, 8'h00);
		run_op(camd_pkg::CAMD_MUL_SIGNED_UNSIGNED, 8'hFF, 8'h00, 8'h00, 8'hFF);
		run_op(camd_pkg::CAMD_FRAC_MUL_SIGNED_UNSIGNED, 8'h40, 8'h00, 8'h00,
			8'h80);
		run_op(camd_pkg::CAMD_BITWISE_INVERT, 8'h00, 8'h00, 8'h00, 8'h00);
		run_op(camd_pkg::CAMD_ARITH_INVERSE, 8'h80, 8'h00, 8'h00, 8'h00);
		run_op(camd_pkg::CAMD_ARITH_INVERSE, 8'h00, 8'h00, 8'h00, 8'h00);
	endtask
	task automatic sc_b2b();
		logic [21:0] e1, e2;
		e1 = ref_op(camd_pkg::CAMD_AND_IMM, 8'hF0, 8'h00, 8'h8F, 8'h00, ef);
		e2 = ref_op(camd_pkg::CAMD_OR_IMM, 8'h00, 8'h00, 8'h00, 8'h00, e1[5:0]);
		ef = e2[5:0];
		drv(camd_pkg::CAMD_AND_IMM, 8'hF0, 8'h00, 8'h8F, 8'h00);
		@(negedge i_core_clk);
		drv(camd_pkg::CAMD_OR_IMM, 8'h00, 8'h00, 8'h00, 8'h00);
		chk(o_result, e1[21:6]);
		@(negedge i_core_clk);
		i_start = 1'b0;
		chk(16'(o_done), 16'h1);
		chk({o_result[9:0], o_flags}, {e2[15:6], ef});
		@(negedge i_core_clk);
	endtask
	task automatic sc_refuse();
		logic [21:0] e;
		e = ref_op(camd_pkg::CAMD_SUB_IMM_WORD, 8'h00, 8'h00, 8'h01, 8'h00, ef);
		ef = e[5:0];
		drv(camd_pkg::CAMD_SUB_IMM_WORD, 8'h00, 8'h00, 8'h01, 8'h00);
		@(negedge i_core_clk);
		chk(16'(o_busy), 16'h1);
		drv(camd_pkg::CAMD_AND_IMM, 8'h00, 8'h00, 8'h00, 8'h00);
		@(negedge i_core_clk);
		i_start = 1'b0;
		chk({o_result[9:0], o_flags}, {e[15:6], ef});
		@(negedge i_core_clk);
		chk({15'h0000, o_done}, 16'h0000);
		chk(m_pair, e[21:6]);
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		fails = 0;
		check_count = 0;
		ef = 6'h00;
		i_rst = 1'b1;
		drv(camd_pkg::CAMD_AND_IMM, 8'h00, 8'h00, 8'h00, 8'h00);
		i_start = 1'b0;
		repeat (4) @(negedge i_core_clk);
		chk(o_result | 16'(o_flags), 16'h0000);
		i_rst = 1'b0;
		sc_ops();
		sc_b2b();
		sc_refuse();
		i_rst = 1'b1;
		@(negedge i_core_clk);
		chk({o_result[9:0], o_flags}, 16'h0000);
		i_rst = 1'b0;
		ef = 6'h00;
		run_op(camd_pkg::CAMD_SUB_IMM_WITH_CARRY, 8'h00, 8'h00, 8'h01, 8'h00);
		end_sim();
	end
	// whole run is about forty cycles; this limit only catches a hang
	initial begin
		#100000;
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
